// File: logic/qdl_defines.svh
`ifndef QDL_DEFINES_SVH
`define QDL_DEFINES_SVH

`define QDL_WORD_BITS 16
`define QDL_CODE_BITS 12
`define QDL_CHANNELS 4
`define QDL_CODE_MSB 15
`define QDL_CODE_LSB 4
`define QDL_ADDR_HI_BIT 3
`define QDL_ADDR_LO_BIT 2
`define QDL_SEL_HI_BIT 1
`define QDL_SEL_LO_BIT 0
`define QDL_CODE_RESET 12'h000
`define QDL_CNT_RESET 5'h00
`define QDL_BIPOLAR_ZERO 12'h800

`endif

// File: logic/qdl_pkg.sv
package qdl_pkg;
   typedef logic [11:0] qdl_code_t;
   typedef logic [15:0] qdl_word_t;
   typedef logic [1:0] qdl_chan_t;
   typedef enum logic [1:0] {
      QDL_IDLE = 2'b00,
      QDL_SHIFT = 2'b01,
      QDL_DONE = 2'b10
   } qdl_state_t;
endpackage

// File: logic/qdl_segment_decode.sv
`timescale 1ns/10ps
// Converter code to switch controls: thermometer on the top two bits, binary ladder below
module qdl_segment_decode (
   // Code in
   input wire qdl_pkg::qdl_code_t code,
   // Switch controls
   output logic [2:0] segment_sw,
   output logic [9:0] ladder_sw
);
   import qdl_pkg::*;

   always_comb begin
      // Each segment switch steers a quarter of the reference current
      segment_sw[0] = code[11] | code[10];
      segment_sw[1] = code[11];
      segment_sw[2] = code[11] & code[10];
      ladder_sw = code[9:0];
   end
endmodule // qdl_segment_decode

// File: logic/qdl_serial_loader.sv
// What this block does
// - Shift serial data in on each falling serial clock edge during a frame.
// - Drive serial data out from the last shift register stage for daisy chaining.
// - Frame sync low marks the word; its rise ends the transfer.
// - After sixteen bits, accept only when DB3/DB2 match the address straps.
// - DB1/DB0 pick one input latch for the twelve data bits; others hold.
// - Update strobe low with clear high copies all input latches to converter latches together.
// - Clear low forces all converter latches to zero code.
// - Clear leaves input latches unchanged so update restores old codes.
// - Top two code bits decode to three quarter-current segment switches.
// - Lower ten code bits drive ten binary ladder switches directly.
// - Unipolar coding is straight binary, steps of one in 4096.
// - Bipolar coding is offset binary, 0x800 is zero, steps one in 2048.
// - Words go MSB first: twelve data bits, address bits, then select bits.
`timescale 1ns/10ps
`include "qdl_defines.svh"
module qdl_serial_loader (
   // System
   input wire logic clk,
   input wire logic srst,
   // Serial link pins
   input wire logic frame_sync_in,
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   output logic serial_data_out,
   // Address straps
   input wire logic addr_strap_high,
   input wire logic addr_strap_low,
   // Update and clear
   input wire logic update_strobe_n,
   input wire logic clear_outputs_n,
   // Converter codes and switch controls
   output qdl_pkg::qdl_code_t dac_code [4],
   output logic [2:0] segment_sw [4],
   output logic [9:0] ladder_sw [4],
   // Status
   output logic word_accepted,
   output logic word_rejected
);
   import qdl_pkg::*;

   // Two-stage synchronisers for every pin input
   logic [4:0] sync1_reg, sync1_next;
   logic [4:0] sync2_reg, sync2_next;
   logic sclk_prev_reg, sclk_prev_next;
   logic fs_n, sclk, sdat, strap_hi, strap_lo, upd_n, clr_n;

   always_comb begin
      sync1_next = {frame_sync_in, serial_clock_in, serial_data_in,
                    addr_strap_high, addr_strap_low};
      sync2_next = sync1_reg;
      sclk_prev_next = sync2_reg[3];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_reg <= 5'h1F;
         sync2_reg <= 5'h1F;
         sclk_prev_reg <= 1'b1;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         sclk_prev_reg <= sclk_prev_next;
      end
   end

   // Separate pair for the asynchronous strobes
   logic [1:0] ctl1_reg, ctl1_next, ctl2_reg, ctl2_next;
   always_comb begin
      ctl1_next = {update_strobe_n, clear_outputs_n};
      ctl2_next = ctl1_reg;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         ctl1_reg <= 2'h3;
         ctl2_reg <= 2'h3;
      end else begin
         ctl1_reg <= ctl1_next;
         ctl2_reg <= ctl2_next;
      end
   end

   always_comb begin
      fs_n = sync2_reg[4];
      sclk = sync2_reg[3];
      sdat = sync2_reg[2];
      strap_hi = sync2_reg[1];
      strap_lo = sync2_reg[0];
      upd_n = ctl2_reg[1];
      clr_n = ctl2_reg[0];
   end

   logic sclk_fall;
   assign sclk_fall = sclk_prev_reg & ~sclk;

   // Frame state, shift register and bit count
   qdl_state_t state_reg, state_next;
   qdl_word_t shift_reg, shift_next;
   logic [4:0] count_reg, count_next;
   logic accept_reg, accept_next, reject_reg, reject_next;
   logic sdo_reg, sdo_next;

   always_comb begin
      state_next = state_reg;
      shift_next = shift_reg;
      count_next = count_reg;
      accept_next = 1'b0;
      reject_next = 1'b0;
      sdo_next = shift_reg[`QDL_CODE_MSB];
      unique case (state_reg)
         QDL_IDLE: begin
            if (!fs_n) begin
               state_next = QDL_SHIFT;
               count_next = `QDL_CNT_RESET;
               if (sclk_fall) begin
                  shift_next = {shift_reg[14:0], sdat};
                  count_next = 5'h01;
               end
            end
         end
         QDL_SHIFT: begin
            if (fs_n) begin
               // Frame ended short of a full word: discard
               state_next = QDL_IDLE;
            end else if (sclk_fall) begin
               shift_next = {shift_reg[14:0], sdat};
               count_next = count_reg + 5'h01;
               if (count_reg == 5'(`QDL_WORD_BITS - 1)) begin
                  state_next = QDL_DONE;
                  if (shift_reg[`QDL_ADDR_HI_BIT - 1] == strap_hi &&
                      shift_reg[`QDL_ADDR_LO_BIT - 1] == strap_lo) begin
                     accept_next = 1'b1;
                  end else begin
                     reject_next = 1'b1;
                  end
               end
            end
         end
         QDL_DONE: begin
            // Keep shifting for the daisy chain, but no further load this frame
            if (fs_n) begin
               state_next = QDL_IDLE;
            end else if (sclk_fall) begin
               shift_next = {shift_reg[14:0], sdat};
            end
         end
         default: state_next = QDL_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= QDL_IDLE;
         shift_reg <= 16'h0000;
         count_reg <= `QDL_CNT_RESET;
         accept_reg <= 1'b0;
         reject_reg <= 1'b0;
         sdo_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         count_reg <= count_next;
         accept_reg <= accept_next;
         reject_reg <= reject_next;
         sdo_reg <= sdo_next;
      end
   end

   // Input and converter latches
   qdl_code_t in_latch_reg [4], in_latch_next [4];
   qdl_code_t dac_latch_reg [4], dac_latch_next [4];
   qdl_chan_t sel;

   always_comb begin
      sel = {shift_reg[`QDL_SEL_HI_BIT], shift_reg[`QDL_SEL_LO_BIT]};
      for (int i = 0; i < `QDL_CHANNELS; i++) begin
         in_latch_next[i] = in_latch_reg[i];
         if (accept_reg && sel == 2'(i)) begin
            in_latch_next[i] = shift_reg[`QDL_CODE_MSB:`QDL_CODE_LSB];
         end
         dac_latch_next[i] = dac_latch_reg[i];
         if (!clr_n) begin
            dac_latch_next[i] = `QDL_CODE_RESET;
         end else if (!upd_n) begin
            dac_latch_next[i] = in_latch_reg[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < `QDL_CHANNELS; i++) begin
            in_latch_reg[i] <= `QDL_CODE_RESET;
            dac_latch_reg[i] <= `QDL_CODE_RESET;
         end
      end else begin
         for (int i = 0; i < `QDL_CHANNELS; i++) begin
            in_latch_reg[i] <= in_latch_next[i];
            dac_latch_reg[i] <= dac_latch_next[i];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `QDL_CHANNELS; g++) begin : g_dec
         qdl_segment_decode u_dec (
            .code(dac_latch_reg[g]),
            .segment_sw(segment_sw[g]),
            .ladder_sw(ladder_sw[g])
         );
      end
   endgenerate

   always_comb begin
      serial_data_out = sdo_reg;
      word_accepted = accept_reg;
      word_rejected = reject_reg;
      for (int i = 0; i < `QDL_CHANNELS; i++) begin
         dac_code[i] = dac_latch_reg[i];
      end
   end
endmodule // qdl_serial_loader

// File: dv/qdl_serial_loader_chk.sv
`timescale 1ns/10ps
module qdl_serial_loader_chk (
   // System
   input wire logic clk,
   input wire logic srst,
   // Pins
   input wire logic frame_sync_in,
   input wire logic update_strobe_n,
   input wire logic clear_outputs_n,
   // Outputs
   input wire qdl_pkg::qdl_code_t dac_code [4],
   input wire logic [2:0] segment_sw [4],
   input wire logic [9:0] ladder_sw [4],
   input wire logic word_accepted,
   input wire logic word_rejected
);
   import qdl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence quiet_ctrl;
      (update_strobe_n && clear_outputs_n) [*5];
   endsequence
   sequence clear_held;
      (!clear_outputs_n) [*4];
   endsequence
   a_pulse_excl: assert property (!(word_accepted && word_rejected)) else $error("both pulses");
   a_accept_single: assert property (word_accepted |=> !word_accepted) else $error("long accept");
   a_reject_single: assert property (word_rejected |=> !word_rejected) else $error("long reject");
   a_idle_quiet: assert property (frame_sync_in [*8] |-> !(word_accepted || word_rejected))
      else $error("pulse outside frame");
   for (genvar k = 0; k < 4; k++) begin : g_ch
      a_clear_zero: assert property (clear_held |=> dac_code[k] == 12'h000) else $error("not cleared");
      a_code_hold: assert property (quiet_ctrl |=> $stable(dac_code[k])) else $error("code moved");
      a_ladder_map: assert property (ladder_sw[k] == dac_code[k][9:0]) else $error("ladder");
      a_segment_map: assert property (
         segment_sw[k] == {&dac_code[k][11:10], dac_code[k][11], |dac_code[k][11:10]})
         else $error("segment");
   end
endmodule // qdl_serial_loader_chk
bind qdl_serial_loader qdl_serial_loader_chk u_chk (.*);

// File: dv/qdl_host_model.sv
`timescale 1ns/10ps
module qdl_host_model (
   // Serial link
   output logic frame_sync_in,
   output logic serial_clock_in,
   output logic serial_data_in
);
   import qdl_pkg::*;
   initial begin
      frame_sync_in = 1'b1;
      serial_clock_in = 1'b1;
      serial_data_in = 1'b0;
   end
   // Clock stands high between frames; released data shows the inverse bit
   // Called on a rising clk edge; every pin change then lands just after an edge
   task automatic send(input qdl_word_t w, input int n);
      #1;
      frame_sync_in = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         serial_clock_in = 1'b1;
         serial_data_in = w[i];
         #80 serial_clock_in = 1'b0;
         #80;
      end
      serial_clock_in = 1'b1;
      serial_data_in = ~serial_data_in;
      #80 frame_sync_in = 1'b1;
      #99;
   endtask
endmodule // qdl_host_model

// File: dv/qdl_serial_loader_test.sv
`timescale 1ns/10ps
module qdl_serial_loader_test;
   import qdl_pkg::*;
   logic clk, srst, frame_sync_in, serial_clock_in, serial_data_in, serial_data_out, addr_strap_high, addr_strap_low;
   logic update_strobe_n, clear_outputs_n, word_accepted, word_rejected;
   qdl_code_t dac_code [4];
   logic [2:0] segment_sw [4];
   logic [9:0] ladder_sw [4];
   logic [47:0] codes = 48'hFFF8005C33A5;
   int errors, checked, n_acc, n_rej;
   qdl_serial_loader u_dut (
      .clk(clk),
      .srst(srst),
      .frame_sync_in(frame_sync_in),
      .serial_clock_in(serial_clock_in),
      .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out),
      .addr_strap_high(addr_strap_high),
      .addr_strap_low(addr_strap_low),
      .update_strobe_n(update_strobe_n),
      .clear_outputs_n(clear_outputs_n),
      .dac_code(dac_code),
      .segment_sw(segment_sw),
      .ladder_sw(ladder_sw),
      .word_accepted(word_accepted),
      .word_rejected(word_rejected)
   );
   qdl_host_model u_host (
      .frame_sync_in(frame_sync_in),
      .serial_clock_in(serial_clock_in),
      .serial_data_in(serial_data_in)
   );
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      n_acc <= n_acc + int'(word_accepted === 1'b1);
      n_rej <= n_rej + int'(word_rejected === 1'b1);
   end
   task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] seen);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic load(input qdl_word_t w, input int n, input int ea, input int er);
      int a0;
      int r0;
      a0 = n_acc;
      r0 = n_rej;
      u_host.send(w, n);
      repeat (8) @(posedge clk);
      cmp("accepted", 16'(ea), 16'(n_acc - a0));
      cmp("rejected", 16'(er), 16'(n_rej - r0));
   endtask
   task automatic pins(input logic u, input logic c);
      #1;
      update_strobe_n = u;
      clear_outputs_n = c;
      repeat (6) @(posedge clk);
   endtask
   // Looks at the falling edge, where the registered codes are settled, and returns on a rising edge
   task automatic codes_are(input logic [47:0] e);
      @(negedge clk);
      for (int k = 0; k < 4; k++) cmp("dac_code", 16'(e[12*k+:12]), 16'(dac_code[k]));
      @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      srst = 1'b1;
      update_strobe_n = 1'b1;
      clear_outputs_n = 1'b1;
      {addr_strap_high, addr_strap_low} = 2'b10;
      repeat (20) @(posedge clk);
      #1;
      srst = 1'b0;
      repeat (4) @(posedge clk);
      codes_are(48'h0);
      for (int k = 0; k < 4; k++) begin
         load({codes[12*k+:12], 2'b10, 2'(k)}, 16, 1, 0);
         cmp("serial_data_out", 16'(codes[12*k+11]), 16'(serial_data_out));
      end
      codes_are(48'h0);
      load({12'h111, 2'b01, 2'b00}, 16, 0, 1);
      load({12'h222, 2'b10, 2'b01}, 10, 0, 0);
      pins(1'b0, 1'b1);
      codes_are(codes);
      cmp("segment_sw", 16'h0003, 16'(segment_sw[2]));
      cmp("segment_sw", 16'h0007, 16'(segment_sw[3]));
      cmp("ladder_sw", 16'h03A5, 16'(ladder_sw[0]));
      pins(1'b1, 1'b0);
      codes_are(48'h0);
      pins(1'b0, 1'b0);
      codes_are(48'h0);
      pins(1'b0, 1'b1);
      codes_are(codes);
      #1;
      {addr_strap_high, addr_strap_low} = 2'b01;
      @(posedge clk);
      load({12'h001, 2'b01, 2'b11}, 16, 1, 0);
      repeat (4) @(posedge clk);
      codes_are({12'h001, codes[35:0]});
      end_of_test();
   end
endmodule // qdl_serial_loader_test
